// File: cmpf_pkg.sv
package cmpf_pkg;

	// ************************************************************
	// bus geometry
	// ************************************************************
	localparam int unsigned AXI_AW = 8;
	localparam int unsigned AXI_DW = 32;
	localparam int unsigned REG_W  = 8;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ************************************************************
	// register indices and byte addresses (index times four)
	// ************************************************************
	localparam logic [7:0] IDX_MONO   = 8'h1a;
	localparam logic [7:0] IDX_PWR    = 8'h1b;
	localparam logic [7:0] IDX_CAP    = 8'h1c;
	localparam logic [7:0] IDX_STATUS = 8'h20;

	localparam logic [AXI_AW-1:0] ADDR_MONO   = AXI_AW'(IDX_MONO * 4);
	localparam logic [AXI_AW-1:0] ADDR_PWR    = AXI_AW'(IDX_PWR * 4);
	localparam logic [AXI_AW-1:0] ADDR_CAP    = AXI_AW'(IDX_CAP * 4);
	localparam logic [AXI_AW-1:0] ADDR_STATUS = AXI_AW'(IDX_STATUS * 4);

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int unsigned MONO_IN_MUTE_BIT  = 7;
	localparam int unsigned MONO_OUT_MUTE_BIT = 6;
	localparam int unsigned ATTEN_W           = 4;
	localparam int unsigned ADC_PD_BIT        = 7;
	localparam int unsigned DAC_PD_BIT        = 6;
	localparam int unsigned MIX_PD_BIT        = 5;
	localparam int unsigned FREQ_REGS_ENABLE_BIT          = 3;
	localparam int unsigned CAP_FMT_HI_BIT    = 7;
	localparam int unsigned CAP_FMT_LO_BIT    = 6;
	localparam int unsigned CAP_COMPAND_BIT   = 5;
	localparam int unsigned CAP_STEREO_BIT    = 4;

	localparam int unsigned ST_FREQ_REGS_BIT  = 0;
	localparam int unsigned ST_ADC_OFF_BIT    = 1;
	localparam int unsigned ST_DAC_OFF_BIT    = 2;
	localparam int unsigned ST_FMT_RSVD_BIT   = 3;
	localparam int unsigned ST_CAP_WR_OK_BIT  = 4;

	// ************************************************************
	// writable masks and reset values
	// ************************************************************
	localparam logic [REG_W-1:0] MONO_WMASK = 8'hcf;
	localparam logic [REG_W-1:0] PWR_WMASK  = 8'he8;
	localparam logic [REG_W-1:0] CAP_WMASK  = 8'hf0;
	localparam logic [REG_W-1:0] MONO_RST   = 8'h03;
	localparam logic [REG_W-1:0] PWR_RST    = 8'h00;
	localparam logic [REG_W-1:0] CAP_RST    = 8'h00;

	// ************************************************************
	// attenuation scale, in tenths of a decibel
	// ************************************************************
	localparam int unsigned ATTEN_DB_W        = 9;
	localparam logic [ATTEN_DB_W-1:0] ATTEN_STEP_TENTH_DB = 9'h01e;

	typedef enum logic [2:0] {
		FMT_U8,
		FMT_MULAW,
		FMT_S16_LE,
		FMT_ALAW,
		FMT_S16_BE,
		FMT_RESERVED
	} cmpf_fmt_t;

endpackage

// File: cmpf_atten_map.sv
`timescale 1ns/1ps

module cmpf_atten_map
	import cmpf_pkg::*;
(
	input  wire logic [ATTEN_W-1:0]    code,
	output logic      [ATTEN_DB_W-1:0] tenth_db
);

	// ************************************************************
	// linear step, no table needed
	// ************************************************************
	always_comb begin
		tenth_db = ATTEN_DB_W'(code * ATTEN_STEP_TENTH_DB);
	end

endmodule // cmpf_atten_map

// File: cmpf_fmt_decode.sv
`timescale 1ns/1ps

module cmpf_fmt_decode
	import cmpf_pkg::*;
(
	input  wire logic fmt_hi,
	input  wire logic fmt_lo,
	input  wire logic compand,
	output cmpf_fmt_t fmt,
	output logic      wide16,
	output logic      companded,
	output logic      big_endian,
	output logic      reserved
);

	// ************************************************************
	// capture data type decode
	// ************************************************************
	always_comb begin
		case ({fmt_hi, fmt_lo, compand})
			3'h0: fmt = FMT_U8;
			3'h1: fmt = FMT_MULAW;
			3'h2: fmt = FMT_S16_LE;
			3'h3: fmt = FMT_ALAW;
			3'h6: fmt = FMT_S16_BE;
			default: fmt = FMT_RESERVED;
		endcase
		wide16     = (fmt == FMT_S16_LE) || (fmt == FMT_S16_BE);
		companded  = (fmt == FMT_MULAW) || (fmt == FMT_ALAW);
		big_endian = (fmt == FMT_S16_BE);
		reserved   = (fmt == FMT_RESERVED);
	end

endmodule // cmpf_fmt_decode

// File: cmpf_regs.sv
`timescale 1ns/1ps

module cmpf_regs
	import cmpf_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [AXI_AW-1:0]     s_axi_awaddr,
	input  wire logic [2:0]            s_axi_awprot,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [AXI_DW-1:0]     s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic      [1:0]            s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [AXI_AW-1:0]     s_axi_araddr,
	input  wire logic [2:0]            s_axi_arprot,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic      [AXI_DW-1:0]     s_axi_rdata,
	output logic      [1:0]            s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  extended_mode,
	input  wire logic                  mode_change_enable_state,
	input  wire logic                  capture_enable_bit,
	input  wire logic                  adc_sample_tick,
	input  wire logic                  dac_sample_tick,
	output logic      [ATTEN_DB_W-1:0] mono_in_atten_tenth_db,
	output logic                       mono_in_muted,
	output logic                       mono_out_muted,
	output logic                       adc_powered_down,
	output logic                       dac_powered_down,
	output logic                       mixer_powered_down,
	output logic                       adc_sample_en,
	output logic                       dac_sample_en,
	output logic                       freq_regs_rate_select,
	output logic                       crystal_divider_active,
	output cmpf_fmt_t                  capture_format,
	output logic                       capture_sample_16bit,
	output logic                       capture_companded,
	output logic                       capture_big_endian,
	output logic                       capture_format_reserved,
	output logic                       capture_stereo,
	output logic                       capture_right_valid
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic                  awready;
		logic                  aw_have;
		logic [AXI_AW-1:0]     aw_addr;
		logic                  wready;
		logic                  w_have;
		logic [REG_W-1:0]      w_data;
		logic                  w_lane0;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [REG_W-1:0]      rdata;
		logic [1:0]            rresp;
		logic [REG_W-1:0]      mono;
		logic [REG_W-1:0]      pwr;
		logic [REG_W-1:0]      cap;
		logic [ATTEN_DB_W-1:0] atten_db;
		logic                  in_muted;
		logic                  out_muted;
		logic                  adc_pd;
		logic                  dac_pd;
		logic                  mix_pd;
		logic                  adc_en;
		logic                  dac_en;
		logic                  freq_sel;
		logic                  xtal_act;
		cmpf_fmt_t             fmt;
		logic                  wide16;
		logic                  compand;
		logic                  big_end;
		logic                  fmt_rsvd;
		logic                  stereo;
		logic                  right_ok;
	} cmpf_state_t;

	cmpf_state_t state_q;
	cmpf_state_t state_d;

	logic [ATTEN_DB_W-1:0] atten_db;
	cmpf_fmt_t             fmt_dec;
	logic                  fmt_wide;
	logic                  fmt_comp;
	logic                  fmt_be;
	logic                  fmt_res;
	logic                  cap_write_ok;
	logic                  dac_off;
	logic                  freq_regs_on;
	logic [REG_W-1:0]      status_word;

	logic                  wr_mono;
	logic                  wr_pwr;
	logic                  wr_cap;
	logic                  wr_status;
	logic                  rd_mono;
	logic                  rd_pwr;
	logic                  rd_cap;
	logic                  rd_status;

	// ************************************************************
	// field decoders
	// ************************************************************
	cmpf_atten_map u_atten (
		.code     (state_q.mono[ATTEN_W-1:0]),
		.tenth_db (atten_db)
	);

	cmpf_fmt_decode u_fmt (
		.fmt_hi     (state_q.cap[CAP_FMT_HI_BIT]),
		.fmt_lo     (state_q.cap[CAP_FMT_LO_BIT]),
		.compand    (state_q.cap[CAP_COMPAND_BIT]),
		.fmt        (fmt_dec),
		.wide16     (fmt_wide),
		.companded  (fmt_comp),
		.big_endian (fmt_be),
		.reserved   (fmt_res)
	);

	// ************************************************************
	// shared terms
	// ************************************************************
	// format bits are frozen while capture runs outside the mode change state,
	// so a stray write cannot retime a stream in flight
	assign cap_write_ok = mode_change_enable_state || !capture_enable_bit;
	assign dac_off      = state_q.pwr[DAC_PD_BIT] || state_q.pwr[MIX_PD_BIT];
	assign freq_regs_on = extended_mode && state_q.pwr[FREQ_REGS_ENABLE_BIT];

	// the write gate bit is live, so software sees the gate as it stands right now
	always_comb begin
		status_word                   = '0;
		status_word[ST_FREQ_REGS_BIT] = state_q.freq_sel;
		status_word[ST_ADC_OFF_BIT]   = state_q.adc_pd;
		status_word[ST_DAC_OFF_BIT]   = state_q.dac_pd;
		status_word[ST_FMT_RSVD_BIT]  = state_q.fmt_rsvd;
		status_word[ST_CAP_WR_OK_BIT] = cap_write_ok;
	end

	// ************************************************************
	// address decode
	// ************************************************************
	// only the word index is compared, so the low two address bits alias
	always_comb begin
		wr_mono   = 1'b0;
		wr_pwr    = 1'b0;
		wr_cap    = 1'b0;
		wr_status = 1'b0;
		if (state_q.aw_addr[AXI_AW-1:2] == ADDR_MONO[AXI_AW-1:2]) begin
			wr_mono = 1'b1;
		end else if (state_q.aw_addr[AXI_AW-1:2] == ADDR_PWR[AXI_AW-1:2]) begin
			wr_pwr = 1'b1;
		end else if (state_q.aw_addr[AXI_AW-1:2] == ADDR_CAP[AXI_AW-1:2]) begin
			wr_cap = 1'b1;
		end else if (state_q.aw_addr[AXI_AW-1:2] == ADDR_STATUS[AXI_AW-1:2]) begin
			wr_status = 1'b1;
		end
	end

	// reads decode the live address, since the answer is built in the take cycle
	always_comb begin
		rd_mono   = 1'b0;
		rd_pwr    = 1'b0;
		rd_cap    = 1'b0;
		rd_status = 1'b0;
		if (s_axi_araddr[AXI_AW-1:2] == ADDR_MONO[AXI_AW-1:2]) begin
			rd_mono = 1'b1;
		end else if (s_axi_araddr[AXI_AW-1:2] == ADDR_PWR[AXI_AW-1:2]) begin
			rd_pwr = 1'b1;
		end else if (s_axi_araddr[AXI_AW-1:2] == ADDR_CAP[AXI_AW-1:2]) begin
			rd_cap = 1'b1;
		end else if (s_axi_araddr[AXI_AW-1:2] == ADDR_STATUS[AXI_AW-1:2]) begin
			rd_status = 1'b1;
		end
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		state_d = state_q;

		// write address and data are taken independently, held until the response
		if (s_axi_awvalid && state_q.awready) begin
			state_d.aw_addr = s_axi_awaddr;
			state_d.aw_have = 1'b1;
			state_d.awready = 1'b0;
		end
		if (s_axi_wvalid && state_q.wready) begin
			state_d.w_data  = s_axi_wdata[REG_W-1:0];
			state_d.w_lane0 = s_axi_wstrb[0];
			state_d.w_have  = 1'b1;
			state_d.wready  = 1'b0;
		end

		if (state_q.aw_have && state_q.w_have && !state_q.bvalid) begin
			state_d.bvalid  = 1'b1;
			state_d.bresp   = RESP_OKAY;
			state_d.aw_have = 1'b0;
			state_d.w_have  = 1'b0;
			// reserved bits are dropped, so they always read back as zero
			if (wr_mono) begin
				if (state_q.w_lane0) begin
					state_d.mono = state_q.w_data & MONO_WMASK;
				end
			end else if (wr_pwr) begin
				if (state_q.w_lane0) begin
					state_d.pwr = state_q.w_data & PWR_WMASK;
				end
			end else if (wr_cap) begin
				// a blocked write still answers okay; only a read-back shows the drop
				if (state_q.w_lane0 && cap_write_ok) begin
					state_d.cap = state_q.w_data & CAP_WMASK;
				end
			end else if (wr_status) begin
				state_d.bresp = RESP_OKAY;
			end else begin
				state_d.bresp = RESP_SLVERR;
			end
		end

		if (state_q.bvalid && s_axi_bready) begin
			state_d.bvalid  = 1'b0;
			state_d.awready = 1'b1;
			state_d.wready  = 1'b1;
		end

		// reads answer one cycle after the address is taken
		if (s_axi_arvalid && state_q.arready) begin
			state_d.arready = 1'b0;
			state_d.rvalid  = 1'b1;
			state_d.rresp   = RESP_OKAY;
			if (rd_mono) begin
				state_d.rdata = state_q.mono;
			end else if (rd_pwr) begin
				state_d.rdata = state_q.pwr;
			end else if (rd_cap) begin
				state_d.rdata = state_q.cap;
			end else if (rd_status) begin
				state_d.rdata = status_word;
			end else begin
				state_d.rdata = '0;
				state_d.rresp = RESP_SLVERR;
			end
		end
		if (state_q.rvalid && s_axi_rready) begin
			state_d.rvalid  = 1'b0;
			state_d.arready = 1'b1;
		end

		// controls follow the stored fields one cycle later
		state_d.atten_db  = atten_db;
		state_d.in_muted  = state_q.mono[MONO_IN_MUTE_BIT];
		state_d.out_muted = state_q.mono[MONO_OUT_MUTE_BIT];
		state_d.adc_pd    = state_q.pwr[ADC_PD_BIT];
		state_d.dac_pd    = dac_off;
		state_d.mix_pd    = state_q.pwr[MIX_PD_BIT];
		// gating the tick rather than the clock keeps one clock tree
		state_d.adc_en    = adc_sample_tick && !state_q.pwr[ADC_PD_BIT];
		state_d.dac_en    = dac_sample_tick && !dac_off;
		state_d.freq_sel  = freq_regs_on;
		state_d.xtal_act  = !freq_regs_on;
		state_d.fmt       = fmt_dec;
		state_d.wide16    = fmt_wide;
		state_d.compand   = fmt_comp;
		state_d.big_end   = fmt_be;
		state_d.fmt_rsvd  = fmt_res;
		state_d.stereo    = state_q.cap[CAP_STEREO_BIT];
		state_d.right_ok  = state_q.cap[CAP_STEREO_BIT];

		if (!aresetn) begin
			state_d         = '0;
			state_d.awready = 1'b1;
			state_d.wready  = 1'b1;
			state_d.arready = 1'b1;
			state_d.mono    = MONO_RST;
			state_d.pwr     = PWR_RST;
			state_d.cap     = CAP_RST;
			state_d.fmt     = FMT_U8;
			state_d.xtal_act = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		state_q <= state_d;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign s_axi_awready           = state_q.awready;
	assign s_axi_wready            = state_q.wready;
	assign s_axi_bresp             = state_q.bresp;
	assign s_axi_bvalid            = state_q.bvalid;
	assign s_axi_arready           = state_q.arready;
	assign s_axi_rdata             = {{(AXI_DW - REG_W){1'b0}}, state_q.rdata};
	assign s_axi_rresp             = state_q.rresp;
	assign s_axi_rvalid            = state_q.rvalid;
	assign mono_in_atten_tenth_db  = state_q.atten_db;
	assign mono_in_muted           = state_q.in_muted;
	assign mono_out_muted          = state_q.out_muted;
	assign adc_powered_down        = state_q.adc_pd;
	assign dac_powered_down        = state_q.dac_pd;
	assign mixer_powered_down      = state_q.mix_pd;
	assign adc_sample_en           = state_q.adc_en;
	assign dac_sample_en           = state_q.dac_en;
	assign freq_regs_rate_select   = state_q.freq_sel;
	assign crystal_divider_active  = state_q.xtal_act;
	assign capture_format          = state_q.fmt;
	assign capture_sample_16bit    = state_q.wide16;
	assign capture_companded       = state_q.compand;
	assign capture_big_endian      = state_q.big_end;
	assign capture_format_reserved = state_q.fmt_rsvd;
	assign capture_stereo          = state_q.stereo;
	assign capture_right_valid     = state_q.right_ok;

endmodule // cmpf_regs

// File: cmpf_regs_monitor.sv
`timescale 1ns/1ps

module cmpf_regs_monitor
	import cmpf_pkg::*;
(
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic                  extended_mode,
	input wire logic                  adc_sample_tick,
	input wire logic                  dac_sample_tick,
	input wire logic [ATTEN_DB_W-1:0] mono_in_atten_tenth_db,
	input wire logic                  mono_in_muted,
	input wire logic                  mono_out_muted,
	input wire logic                  adc_powered_down,
	input wire logic                  dac_powered_down,
	input wire logic                  mixer_powered_down,
	input wire logic                  adc_sample_en,
	input wire logic                  dac_sample_en,
	input wire logic                  freq_regs_rate_select,
	input wire logic                  crystal_divider_active,
	input wire cmpf_fmt_t             capture_format,
	input wire logic                  capture_sample_16bit,
	input wire logic                  capture_companded,
	input wire logic                  capture_big_endian,
	input wire logic                  capture_format_reserved,
	input wire logic                  capture_stereo,
	input wire logic                  capture_right_valid
);
	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// reset itself is the antecedent here, so it must not disable the check
	property p_rst;
		disable iff (1'h0) !aresetn |=> !mono_in_muted && !mono_out_muted && !adc_powered_down
			&& !dac_powered_down && !mixer_powered_down && !freq_regs_rate_select
			&& capture_format == FMT_U8 && !capture_stereo;
	endproperty
	property p_att_rst; $rose(aresetn) |-> ##2 mono_in_atten_tenth_db == 9'h05a; endproperty
	property p_att; mono_in_atten_tenth_db <= 9'h1c2 && mono_in_atten_tenth_db % 30 == 0; endproperty
	property p_xtal; crystal_divider_active == !freq_regs_rate_select; endproperty
	property p_freq; freq_regs_rate_select |-> $past(extended_mode); endproperty
	property p_adc; adc_sample_en |-> $past(adc_sample_tick) && !adc_powered_down; endproperty
	property p_dac; dac_sample_en |-> $past(dac_sample_tick) && !dac_powered_down; endproperty
	property p_mix; mixer_powered_down |-> dac_powered_down; endproperty
	property p_right; capture_right_valid == capture_stereo; endproperty
	property p_rsvd; capture_format_reserved == (capture_format == FMT_RESERVED); endproperty
	property p_flags;
		capture_format != FMT_RESERVED |->
			capture_sample_16bit == (capture_format inside {FMT_S16_LE, FMT_S16_BE})
			&& capture_companded == (capture_format inside {FMT_MULAW, FMT_ALAW})
			&& capture_big_endian == (capture_format == FMT_S16_BE);
	endproperty

	// ************************************************************
	// assertions and covers
	// ************************************************************
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	a_att_rst: assert property (p_att_rst) else $error("reset attenuation wrong");
	a_att: assert property (p_att) else $error("attenuation off the 3 dB grid");
	a_xtal: assert property (p_xtal) else $error("divider select not inverse");
	a_freq: assert property (p_freq) else $error("rate select outside extended mode");
	a_adc: assert property (p_adc) else $error("adc sample enable wrong");
	a_dac: assert property (p_dac) else $error("dac sample enable wrong");
	a_mix: assert property (p_mix) else $error("mixer down without dac down");
	a_right: assert property (p_right) else $error("right valid mismatch");
	a_rsvd: assert property (p_rsvd) else $error("reserved flag mismatch");
	a_flags: assert property (p_flags) else $error("format flags mismatch");
	c_adc: cover property (adc_sample_en);
	c_freq: cover property (freq_regs_rate_select);
	c_be: cover property (capture_format == FMT_S16_BE);
endmodule // cmpf_regs_monitor

bind cmpf_regs cmpf_regs_monitor u_mon (.*);

// File: cmpf_regs_bench.sv
`timescale 1ns/1ps

module cmpf_regs_bench
	import cmpf_pkg::*;
;
	typedef struct packed {
		logic [7:0]  a;
		logic [7:0]  d;
		logic [11:0] o;
	} cmpf_row_t;

	logic                  aclk = 1'h0, aresetn = 1'h0;
	logic [AXI_AW-1:0]     s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0]            s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [AXI_DW-1:0]     s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]            s_axi_wstrb = 4'h1;
	logic                  s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic                  s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]            s_axi_bresp, s_axi_rresp, rsp;
	logic                  extended_mode = 1'h1, mode_change_enable_state = 1'h0;
	logic                  capture_enable_bit = 1'h0, adc_sample_tick = 1'h0, dac_sample_tick = 1'h0;
	logic [ATTEN_DB_W-1:0] mono_in_atten_tenth_db;
	logic                  mono_in_muted, mono_out_muted, adc_powered_down, dac_powered_down;
	logic                  mixer_powered_down, adc_sample_en, dac_sample_en;
	logic                  freq_regs_rate_select, crystal_divider_active, capture_stereo;
	cmpf_fmt_t             capture_format;
	logic                  capture_sample_16bit, capture_companded, capture_big_endian;
	logic                  capture_format_reserved, capture_right_valid;
	logic [31:0]           rd;
	int                    mismatches = 0, n_checks = 0;

	// o holds the expected output bundle that obs() gathers for that register
	localparam cmpf_row_t ROWS [18] = '{
		'{ADDR_MONO, 8'h00, 12'h000}, '{ADDR_MONO, 8'h0f, 12'h1c2}, '{ADDR_MONO, 8'h85, 12'h496},
		'{ADDR_MONO, 8'h4a, 12'h32c}, '{ADDR_PWR, 8'h80, 12'h011}, '{ADDR_PWR, 8'h40, 12'h009},
		'{ADDR_PWR, 8'h20, 12'h00d}, '{ADDR_PWR, 8'h08, 12'h002}, '{ADDR_CAP, 8'h00, 12'h000},
		'{ADDR_CAP, 8'h20, 12'h004}, '{ADDR_CAP, 8'h40, 12'h008}, '{ADDR_CAP, 8'h60, 12'h00c},
		'{ADDR_CAP, 8'h80, 12'h014}, '{ADDR_CAP, 8'ha0, 12'h014}, '{ADDR_CAP, 8'hc0, 12'h010},
		'{ADDR_CAP, 8'he0, 12'h014}, '{ADDR_CAP, 8'h10, 12'h003}, '{ADDR_CAP, 8'hd0, 12'h013}
	};

	cmpf_regs u_dut (.*);

	initial forever #20 aclk = ~aclk;

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [11:0] obs(logic [7:0] a);
		case (a)
			ADDR_MONO: obs = {1'h0, mono_in_muted, mono_out_muted, mono_in_atten_tenth_db};
			ADDR_PWR: obs = {7'h0, adc_powered_down, dac_powered_down, mixer_powered_down,
				freq_regs_rate_select, crystal_divider_active};
			default: obs = {7'h0, capture_format, capture_stereo, capture_right_valid};
		endcase
	endfunction

	// waits two edges after the response so that derived outputs have settled
	task automatic wr(logic [7:0] a, logic [7:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'h0;
		repeat (2) @(posedge aclk);
	endtask

	task automatic rdr(logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask

	task automatic tick(logic [1:0] e);
		adc_sample_tick <= 1'h1;
		dac_sample_tick <= 1'h1;
		@(posedge aclk);
		adc_sample_tick <= 1'h0;
		dac_sample_tick <= 1'h0;
		@(posedge aclk);
		chk("sample_en", {30'h0, adc_sample_en, dac_sample_en}, {30'h0, e});
	endtask

	task automatic final_report();
		$display("TB: checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#(40 * 4000);
		mismatches++;
		final_report();
	end

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (3) @(posedge aclk);
		foreach (ROWS[i]) begin
			wr(ROWS[i].a, ROWS[i].d);
			chk("wr_resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
			rdr(ROWS[i].a);
			chk("rd_data", rd, {24'h0, ROWS[i].d});
			chk("outputs", {20'h0, obs(ROWS[i].a)}, {20'h0, ROWS[i].o});
		end
		$display("TB: test rows done");
		extended_mode <= 1'h0;
		repeat (2) @(posedge aclk);
		chk("mode_off", {20'h0, obs(ADDR_PWR)}, 32'h001);
		tick(2'h3);
		wr(ADDR_PWR, 8'h40);
		tick(2'h2);
		wr(ADDR_PWR, 8'h20);
		tick(2'h2);
		wr(ADDR_PWR, 8'h80);
		tick(2'h1);
		$display("TB: test power done");
		rdr(ADDR_STATUS);
		chk("status", rd, 32'h12);
		// capture running without mode change state: the write must be dropped
		capture_enable_bit <= 1'h1;
		wr(ADDR_CAP, 8'h40);
		rdr(ADDR_CAP);
		chk("cap_locked", rd, 32'hd0);
		rdr(ADDR_STATUS);
		chk("status_locked", rd, 32'h02);
		mode_change_enable_state <= 1'h1;
		wr(ADDR_CAP, 8'h40);
		rdr(ADDR_CAP);
		chk("cap_mce", rd, 32'h40);
		capture_enable_bit <= 1'h0;
		mode_change_enable_state <= 1'h0;
		s_axi_wstrb <= 4'h0;
		wr(ADDR_MONO, 8'h00);
		s_axi_wstrb <= 4'h1;
		rdr(ADDR_MONO);
		chk("no_strobe", rd, 32'h4a);
		rdr(8'h00);
		chk("unmapped_rd", {30'h0, rsp}, {30'h0, RESP_SLVERR});
		chk("unmapped_data", rd, 32'h0);
		wr(8'h04, 8'h00);
		chk("unmapped_wr", {30'h0, rsp}, {30'h0, RESP_SLVERR});
		$display("TB: test awkward done");
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (3) @(posedge aclk);
		chk("rst_mono_out", {20'h0, obs(ADDR_MONO)}, 32'h05a);
		chk("rst_pwr_out", {20'h0, obs(ADDR_PWR)}, 32'h001);
		chk("rst_cap_out", {20'h0, obs(ADDR_CAP)}, 32'h000);
		rdr(ADDR_MONO);
		chk("rst_mono", rd, 32'h03);
		rdr(ADDR_PWR);
		chk("rst_pwr", rd, 32'h00);
		rdr(ADDR_CAP);
		chk("rst_cap", rd, 32'h00);
		$display("TB: test reset done");
		final_report();
	end
endmodule // cmpf_regs_bench
